// >>> tb_top.sv
`timescale 1ns/1ps
`include "uvsub_params.svh"
module tb_top;
    localparam logic [31:0] CTRL_INIT = 32'h5a0f_00c3;
    localparam int LIMIT = 2000;
    typedef struct packed {
        logic [4:0] so;
        logic [5:0] fn;
        logic [63:0] l;
        logic [63:0] r;
        logic uf;
    } uvsub_row_t;
    uvsub_row_t rows [8] = '{
        '{`UVSUB_SO_QB_WRAP, `UVSUB_FN_QUAD_BYTE, 64'hffff_ffff_8070_0510, 64'h0070_0611, 1'b1},
        '{`UVSUB_SO_QB_SAT, `UVSUB_FN_QUAD_BYTE, 64'hffff_ffff_8070_0510, 64'h0070_0611, 1'b1},
        '{`UVSUB_SO_QB_WRAP, `UVSUB_FN_QUAD_BYTE, 64'h7f20_3040, 64'hffff_ffff_0010_3000, 1'b0},
        '{`UVSUB_SO_QH_WRAP, `UVSUB_FN_OCTAL_BYTE, 64'h0001_0005_0000_1234,
            64'h0002_0003_ffff_1234, 1'b1},
        '{`UVSUB_SO_QH_SAT, `UVSUB_FN_OCTAL_BYTE, 64'h0001_0005_0000_1234,
            64'h0002_0003_ffff_1234, 1'b1},
        '{`UVSUB_SO_QH_WRAP, `UVSUB_FN_OCTAL_BYTE, 64'h0001_0002_0003, 64'hffff_0001_0003_0004, 1'b0},
        '{`UVSUB_SO_OB_HALF, `UVSUB_FN_OCTAL_BYTE, 64'h00ff_0102_8000_0304, 64'h0100_0201_0080_0403, 1'b0},
        '{`UVSUB_SO_OB_HALF_RND, `UVSUB_FN_OCTAL_BYTE, 64'h00ff_0102_8000_0304,
            64'h0100_0201_0080_0403, 1'b0}};
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic req = 1'b0;
    logic req_enable = 1'b1;
    logic [31:0] req_instr = '0;
    logic [63:0] req_left = '0;
    logic [63:0] req_right = '0;
    logic issue, ext_enable, result_valid, ctrl_write, exc_reserved, exc_disabled;
    logic [31:0] instr, ctrl_word_in, ctrl_word;
    logic [63:0] left, right, result, exp_res;
    logic [4:0] result_dest, exp_dest;
    logic [31:0] exp_ctrl, pctrl;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    uvsub_pipe_model #(.CTRL_INIT(CTRL_INIT)) u_uvsub_pipe_model (.core_clk_i(core_clk),
        .rst_b_i(rst_b), .req_i(req), .req_instr_i(req_instr), .req_left_i(req_left),
        .req_right_i(req_right), .req_enable_i(req_enable), .ctrl_write_i(ctrl_write),
        .ctrl_word_i(ctrl_word), .issue_o(issue), .instr_o(instr), .ext_enable_o(ext_enable),
        .left_o(left), .right_o(right), .ctrl_word_o(ctrl_word_in));
    uvsub_top u_uvsub_top (.core_clk_i(core_clk), .rst_b_i(rst_b), .issue_i(issue),
        .instr_i(instr), .ext_enable_i(ext_enable), .left_operand_reg_i(left),
        .right_operand_reg_i(right), .ctrl_word_i(ctrl_word_in), .result_valid_o(result_valid),
        .result_dest_o(result_dest), .result_o(result), .ctrl_write_o(ctrl_write),
        .ctrl_word_o(ctrl_word), .exc_reserved_o(exc_reserved), .exc_disabled_o(exc_disabled));
    // ----------------------------------------
    // Reference lanes and compare helpers
    // ----------------------------------------
    function automatic logic [63:0] ref_op(input logic [4:0] so, input logic [63:0] l,
        input logic [63:0] r);
        logic [63:0] res;
        logic [8:0] d9;
        logic [16:0] d17;
        res = '0;
        for (int i = 0; i < 8; i++) begin
            d9 = {1'b0, l[8*i+:8]} - {1'b0, r[8*i+:8]};
            if (so == `UVSUB_SO_OB_HALF || so == `UVSUB_SO_OB_HALF_RND) begin
                res[8*i+:8] = (d9 + {8'h00, so == `UVSUB_SO_OB_HALF_RND}) >> 1;
            end else if (i < 4 && (so == `UVSUB_SO_QB_WRAP || so == `UVSUB_SO_QB_SAT)) begin
                res[8*i+:8] = (d9[8] && so == `UVSUB_SO_QB_SAT) ? 8'h00 : d9[7:0];
            end
        end
        for (int i = 0; i < 4; i++) begin
            d17 = {1'b0, r[16*i+:16]} - {1'b0, l[16*i+:16]};
            if (so == `UVSUB_SO_QH_WRAP || so == `UVSUB_SO_QH_SAT) begin
                res[16*i+:16] = (d17[16] && so == `UVSUB_SO_QH_SAT) ? 16'h0000 : d17[15:0];
            end
        end
        if (so == `UVSUB_SO_QB_WRAP || so == `UVSUB_SO_QB_SAT) begin
            res[63:32] = {32{res[31]}};
        end
        return res;
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_out(input logic v, input logic w, input logic er, input logic ed);
        chk(result_valid, v);
        chk(result_dest, exp_dest);
        chk(result, exp_res);
        chk(ctrl_write, w);
        chk(ctrl_word, exp_ctrl);
        chk(exc_reserved, er);
        chk(exc_disabled, ed);
    endtask
    task automatic expect_ok(input logic [4:0] so, input logic [63:0] l, input logic [63:0] r,
        input logic [4:0] d, input logic w);
        exp_res = ref_op(so, l, r);
        exp_dest = d;
        exp_ctrl = pctrl | (32'(w) << `UVSUB_UNDERFLOW_BIT);
        pctrl = exp_ctrl;
    endtask
    task automatic drive(input logic [5:0] maj, input logic [4:0] so, input logic [5:0] fn,
        input logic [63:0] l, input logic [63:0] r, input logic [4:0] d);
        req <= 1'b1;
        req_instr <= {maj, 5'h03, 5'h07, d, so, fn};
        req_left <= l;
        req_right <= r;
    endtask
    // Single op at an edge, checked, then pulses seen to drop
    task automatic one(input logic [5:0] maj, input logic [4:0] so, input logic [5:0] fn,
        input logic [63:0] l, input logic [63:0] r, input logic en, input logic v,
        input logic w, input logic er, input logic ed);
        drive(maj, so, fn, l, r, 5'h1f);
        req_enable <= en;
        @(posedge core_clk);
        req <= 1'b0;
        #1;
        if (v) expect_ok(so, l, r, 5'h1f, w);
        check_out(v, w, er, ed);
        @(posedge core_clk);
        #1;
        check_out(1'b0, 1'b0, 1'b0, 1'b0);
        @(posedge core_clk);
    endtask
    task automatic stop_test();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            fail_count++;
            stop_test();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        exp_res = '0;
        exp_dest = '0;
        exp_ctrl = '0;
        pctrl = CTRL_INIT;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        for (int i = 0; i <= 8; i++) begin
            if (i < 8) drive(`UVSUB_EXT_MAJOR, rows[i].so, rows[i].fn, rows[i].l, rows[i].r,
                5'(i + 1));
            else req <= 1'b0;
            if (i > 0) begin
                #1;
                expect_ok(rows[i-1].so, rows[i-1].l, rows[i-1].r, 5'(i), rows[i-1].uf);
                check_out(1'b1, rows[i-1].uf, 1'b0, 1'b0);
            end
            @(posedge core_clk);
        end
        $display("test rows done");
        rst_b <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1;
        exp_res = '0;
        exp_dest = '0;
        exp_ctrl = '0;
        pctrl = CTRL_INIT;
        check_out(1'b0, 1'b0, 1'b0, 1'b0);
        @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        $display("test reset done");
        one(`UVSUB_EXT_MAJOR, `UVSUB_SO_QB_SAT, `UVSUB_FN_QUAD_BYTE, rows[0].l, rows[0].r,
            1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        one(6'h1e, `UVSUB_SO_QB_WRAP, `UVSUB_FN_QUAD_BYTE, rows[0].l, rows[0].r,
            1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        one(`UVSUB_EXT_MAJOR, 5'h02, `UVSUB_FN_QUAD_BYTE, rows[0].l, rows[0].r,
            1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        one(`UVSUB_EXT_MAJOR, `UVSUB_SO_QH_WRAP, `UVSUB_FN_QUAD_BYTE, rows[3].l, rows[3].r,
            1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        one(`UVSUB_EXT_MAJOR, `UVSUB_SO_QB_WRAP, 6'h11, rows[0].l, rows[0].r,
            1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        one(`UVSUB_EXT_MAJOR, `UVSUB_SO_QB_SAT, `UVSUB_FN_QUAD_BYTE, rows[0].l, rows[0].r,
            1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
        one(`UVSUB_EXT_MAJOR, `UVSUB_SO_OB_HALF_RND, `UVSUB_FN_OCTAL_BYTE, rows[7].l, rows[7].r,
            1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        $display("test refusals done");
        stop_test();
    end
endmodule

// >>> uvsub_dec_if.sv
`timescale 1ns/1ps
interface uvsub_dec_if;
    import uvsub_pkg::*;
    logic [31:0] instr;
    logic ext_enable;
    uvsub_op_t op;
    logic recognised;
    logic reserved;
    logic disabled;
    logic [4:0] dest;
    modport decoder (input instr, input ext_enable, output op, output recognised,
        output reserved, output disabled, output dest);
    modport user (output instr, output ext_enable, input op, input recognised,
        input reserved, input disabled, input dest);
endinterface

// >>> uvsub_decode.sv
`timescale 1ns/1ps
`include "uvsub_params.svh"
module uvsub_decode
    import uvsub_pkg::*;
(
    uvsub_dec_if.decoder dec
);
    logic is_major;
    logic [4:0] subop;
    logic [5:0] func;

    // ----------------------------------------
    // Field decode
    // ----------------------------------------
    assign is_major = dec.instr[`UVSUB_OPC_HI:`UVSUB_OPC_LO] == `UVSUB_EXT_MAJOR;
    assign subop = dec.instr[`UVSUB_SUBOP_HI:`UVSUB_SUBOP_LO];
    assign func = dec.instr[`UVSUB_FUNC_HI:`UVSUB_FUNC_LO];
    assign dec.dest = dec.instr[`UVSUB_DEST_HI:`UVSUB_DEST_LO];

    always_comb begin
        dec.op = UVSUB_OP_NONE;
        if (is_major && func == `UVSUB_FN_QUAD_BYTE) begin
            if (subop == `UVSUB_SO_QB_WRAP) begin
                dec.op = UVSUB_OP_QB_WRAP;
            end else if (subop == `UVSUB_SO_QB_SAT) begin
                dec.op = UVSUB_OP_QB_SAT;
            end
        end else if (is_major && func == `UVSUB_FN_OCTAL_BYTE) begin
            if (subop == `UVSUB_SO_QH_WRAP) begin
                dec.op = UVSUB_OP_QH_WRAP;
            end else if (subop == `UVSUB_SO_QH_SAT) begin
                dec.op = UVSUB_OP_QH_SAT;
            end else if (subop == `UVSUB_SO_OB_HALF) begin
                dec.op = UVSUB_OP_OB_HALF;
            end else if (subop == `UVSUB_SO_OB_HALF_RND) begin
                dec.op = UVSUB_OP_OB_HALF_RND;
            end
        end
    end

    // Only encoding faults and a disabled extension raise exceptions
    assign dec.recognised = dec.op != UVSUB_OP_NONE && dec.ext_enable;
    assign dec.reserved = dec.op == UVSUB_OP_NONE;
    assign dec.disabled = dec.op != UVSUB_OP_NONE && !dec.ext_enable;
endmodule

// >>> uvsub_lanes.sv
`timescale 1ns/1ps
module uvsub_lanes
    import uvsub_pkg::*;
(
    input wire uvsub_op_t op_i,
    input wire logic [63:0] left_i,
    input wire logic [63:0] right_i,
    output logic [63:0] result_o,
    output logic underflow_o
);
    // Zero-extended byte difference, bit 8 is the borrow
    function automatic logic [8:0] diff8(input logic [7:0] a, input logic [7:0] b);
        diff8 = {1'b0, a} - {1'b0, b};
    endfunction

    // Zero-extended halfword difference, bit 16 is the borrow
    function automatic logic [16:0] diff16(input logic [15:0] a, input logic [15:0] b);
        diff16 = {1'b0, a} - {1'b0, b};
    endfunction

    logic [8:0] qb_d [4];
    logic [16:0] qh_d [4];
    logic [8:0] ob_d [8];
    logic [31:0] qb_res;
    logic qb_uf;
    logic qh_uf;
    logic [63:0] qh_res;
    logic [63:0] ob_res;
    logic sat;
    logic rnd;

    assign sat = op_i == UVSUB_OP_QB_SAT || op_i == UVSUB_OP_QH_SAT;
    assign rnd = op_i == UVSUB_OP_OB_HALF_RND;

    // ----------------------------------------
    // Lane arithmetic
    // ----------------------------------------
    always_comb begin
        qb_res = '0;
        qh_res = '0;
        ob_res = '0;
        qb_uf = 1'b0;
        qh_uf = 1'b0;
        for (int i = 0; i < 4; i++) begin
            qb_d[i] = diff8(left_i[8*i +: 8], right_i[8*i +: 8]);
            qb_uf = qb_uf | qb_d[i][8];
            qb_res[8*i +: 8] = (sat && qb_d[i][8]) ? 8'h00 : qb_d[i][7:0];
            qh_d[i] = diff16(right_i[16*i +: 16], left_i[16*i +: 16]);
            qh_uf = qh_uf | qh_d[i][16];
            qh_res[16*i +: 16] = (sat && qh_d[i][16]) ? 16'h0000 : qh_d[i][15:0];
        end
        for (int j = 0; j < 8; j++) begin
            ob_d[j] = diff8(left_i[8*j +: 8], right_i[8*j +: 8]) + {8'h00, rnd};
            ob_res[8*j +: 8] = ob_d[j][8:1];
        end
    end

    always_comb begin
        result_o = '0;
        underflow_o = 1'b0;
        unique case (op_i)
            UVSUB_OP_QB_WRAP, UVSUB_OP_QB_SAT: begin
                result_o = {{32{qb_res[31]}}, qb_res};
                underflow_o = qb_uf;
            end
            UVSUB_OP_QH_WRAP, UVSUB_OP_QH_SAT: begin
                result_o = qh_res;
                underflow_o = qh_uf;
            end
            UVSUB_OP_OB_HALF, UVSUB_OP_OB_HALF_RND: begin
                result_o = ob_res;
                underflow_o = 1'b0;
            end
            UVSUB_OP_NONE: begin
                result_o = '0;
            end
            default: begin
                result_o = '0;
            end
        endcase
    end
endmodule

// >>> uvsub_params.svh
`ifndef UVSUB_PARAMS_SVH
`define UVSUB_PARAMS_SVH
`define UVSUB_OPC_HI 31
`define UVSUB_OPC_LO 26
`define UVSUB_LEFT_HI 25
`define UVSUB_LEFT_LO 21
`define UVSUB_RIGHT_HI 20
`define UVSUB_RIGHT_LO 16
`define UVSUB_DEST_HI 15
`define UVSUB_DEST_LO 11
`define UVSUB_SUBOP_HI 10
`define UVSUB_SUBOP_LO 6
`define UVSUB_FUNC_HI 5
`define UVSUB_FUNC_LO 0
`define UVSUB_EXT_MAJOR 6'h1F
`define UVSUB_FN_QUAD_BYTE 6'h10
`define UVSUB_FN_OCTAL_BYTE 6'h14
`define UVSUB_SO_QB_WRAP 5'h01
`define UVSUB_SO_QB_SAT 5'h05
`define UVSUB_SO_QH_WRAP 5'h09
`define UVSUB_SO_QH_SAT 5'h0D
`define UVSUB_SO_OB_HALF 5'h19
`define UVSUB_SO_OB_HALF_RND 5'h1B
`define UVSUB_UNDERFLOW_BIT 20
`define UVSUB_CTRL_RESET 32'h0000_0000
`endif

// >>> uvsub_pipe_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Decode and register file stage model
// ----------------------------------------
module uvsub_pipe_model #(
    parameter logic [31:0] CTRL_INIT = 32'h5a0f_00c3
) (
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic req_i,
    input wire logic [31:0] req_instr_i,
    input wire logic [63:0] req_left_i,
    input wire logic [63:0] req_right_i,
    input wire logic req_enable_i,
    input wire logic ctrl_write_i,
    input wire logic [31:0] ctrl_word_i,
    output logic issue_o,
    output logic [31:0] instr_o,
    output logic ext_enable_o,
    output logic [63:0] left_o,
    output logic [63:0] right_o,
    output logic [31:0] ctrl_word_o
);
    logic [31:0] ctrl_r;
    // Pipeline copy of the control word
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            ctrl_r <= CTRL_INIT;
        end else if (ctrl_write_i) begin
            ctrl_r <= ctrl_word_i;
        end
    end
    // Forwarding so back-to-back ops see a pending write-back
    assign ctrl_word_o = ctrl_write_i ? ctrl_word_i : ctrl_r;
    assign issue_o = req_i;
    assign ext_enable_o = req_enable_i;
    // Idle cycles show inverted fields, never the last values
    assign instr_o = req_i ? req_instr_i : ~req_instr_i;
    assign left_o = req_i ? req_left_i : ~req_left_i;
    assign right_o = req_i ? req_right_i : ~req_right_i;
endmodule

// >>> uvsub_pkg.sv
package uvsub_pkg;
    typedef enum logic [2:0] {
        UVSUB_OP_NONE,
        UVSUB_OP_QB_WRAP,
        UVSUB_OP_QB_SAT,
        UVSUB_OP_QH_WRAP,
        UVSUB_OP_QH_SAT,
        UVSUB_OP_OB_HALF,
        UVSUB_OP_OB_HALF_RND
    } uvsub_op_t;
endpackage

// >>> uvsub_top.sv
`timescale 1ns/1ps
`include "uvsub_params.svh"
// Contract
// - Decode major opcode 011111 with fixed source, destination, sub-op, function fields
// - Quad-byte subtract: sub-op 00001 wrap, 00101 saturate, function 010000
// - Quad-halfword subtract: sub-op 01001 wrap, 01101 saturate, function 010100
// - Octal-byte halving: sub-op 11001 truncate, 11011 round, function 010100
// - Quad-byte: left byte minus right byte, wrap modulo 256
// - Saturating quad-byte clamps underflowed lanes to 0x00
// - Quad-byte: top lane MSB fills upper 32 result bits
// - Quad-byte underflow in any lane sets control bit 20
// - Byte underflow is bit 8 of 9-bit zero-extended difference
// - Quad-halfword: right lane minus left lane, all 64 bits written
// - Saturating quad-halfword clamps underflowed lanes to 0x0000
// - Quad-halfword underflow in any lane sets control bit 20
// - Halfword underflow is bit 16 of 17-bit zero-extended difference
// - Octal-byte: left minus right per byte, shifted right one
// - Rounding halving form adds one before the shift
// - Halving forms leave the underflow field untouched
// - Only reserved-instruction and extension-disabled exceptions are raised
module uvsub_top
    import uvsub_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic issue_i,
    input wire logic [31:0] instr_i,
    input wire logic ext_enable_i,
    input wire logic [63:0] left_operand_reg_i,
    input wire logic [63:0] right_operand_reg_i,
    input wire logic [31:0] ctrl_word_i,
    output logic result_valid_o,
    output logic [4:0] result_dest_o,
    output logic [63:0] result_o,
    output logic ctrl_write_o,
    output logic [31:0] ctrl_word_o,
    output logic exc_reserved_o,
    output logic exc_disabled_o
);
    uvsub_dec_if dec_bus();
    logic [63:0] lane_res;
    logic lane_uf;
    logic go;
    logic result_valid_r;
    logic [4:0] result_dest_r;
    logic [63:0] result_r;
    logic ctrl_write_r;
    logic [31:0] ctrl_word_r;
    logic exc_reserved_r;
    logic exc_disabled_r;
    logic [31:0] ctrl_nxt;

    // ----------------------------------------
    // Decode and lanes
    // ----------------------------------------
    assign dec_bus.instr = instr_i;
    assign dec_bus.ext_enable = ext_enable_i;

    uvsub_decode u_dec (
        .dec(dec_bus.decoder)
    );

    uvsub_lanes u_lanes (
        .op_i(dec_bus.op),
        .left_i(left_operand_reg_i),
        .right_i(right_operand_reg_i),
        .result_o(lane_res),
        .underflow_o(lane_uf)
    );

    assign go = issue_i && dec_bus.recognised;

    always_comb begin
        ctrl_nxt = ctrl_word_i;
        if (lane_uf) begin
            ctrl_nxt[`UVSUB_UNDERFLOW_BIT] = 1'b1;
        end
    end

    // ----------------------------------------
    // Result stage
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            result_valid_r <= 1'b0;
            result_dest_r <= '0;
            result_r <= '0;
        end else begin
            result_valid_r <= go;
            if (go) begin
                result_dest_r <= dec_bus.dest;
                result_r <= lane_res;
            end
        end
    end

    // ----------------------------------------
    // Control word update
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            ctrl_write_r <= 1'b0;
            ctrl_word_r <= `UVSUB_CTRL_RESET;
        end else begin
            ctrl_write_r <= go && lane_uf;
            if (go) begin
                ctrl_word_r <= ctrl_nxt;
            end
        end
    end

    // ----------------------------------------
    // Exceptions
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_b_i) begin
            exc_reserved_r <= 1'b0;
            exc_disabled_r <= 1'b0;
        end else begin
            exc_reserved_r <= issue_i && dec_bus.reserved;
            exc_disabled_r <= issue_i && dec_bus.disabled;
        end
    end

    assign result_valid_o = result_valid_r;
    assign result_dest_o = result_dest_r;
    assign result_o = result_r;
    assign ctrl_write_o = ctrl_write_r;
    assign ctrl_word_o = ctrl_word_r;
    assign exc_reserved_o = exc_reserved_r;
    assign exc_disabled_o = exc_disabled_r;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_issue_op(uvsub_op_t o);
        issue_i && dec_bus.recognised && dec_bus.op == o;
    endsequence

    a_qb_sign_fill: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        s_issue_op(UVSUB_OP_QB_WRAP) or s_issue_op(UVSUB_OP_QB_SAT)
        |=> result_o[63:32] == {32{result_o[31]}})
        else $error("quad byte sign fill wrong");

    a_qb_wrap_lane: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        s_issue_op(UVSUB_OP_QB_WRAP)
        |=> result_o[7:0] == 8'($past(left_operand_reg_i[7:0]) - $past(right_operand_reg_i[7:0])))
        else $error("quad byte wrap lane wrong");

    a_qb_sat_zero: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        s_issue_op(UVSUB_OP_QB_SAT) ##0 (left_operand_reg_i[15:8] < right_operand_reg_i[15:8])
        |=> result_o[15:8] == 8'h00)
        else $error("quad byte saturation missed");

    a_qh_order: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        s_issue_op(UVSUB_OP_QH_WRAP)
        |=> result_o[63:48] == 16'($past(right_operand_reg_i[63:48])
            - $past(left_operand_reg_i[63:48])))
        else $error("quad half operand order wrong");

    a_qh_sat_zero: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        s_issue_op(UVSUB_OP_QH_SAT) ##0 (right_operand_reg_i[47:32] < left_operand_reg_i[47:32])
        |=> result_o[47:32] == 16'h0000)
        else $error("quad half saturation missed");

    a_ob_round: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        s_issue_op(UVSUB_OP_OB_HALF_RND)
        |=> result_o[63:56] == 8'((9'($past(left_operand_reg_i[63:56]))
            - 9'($past(right_operand_reg_i[63:56])) + 9'd1) >> 1))
        else $error("halving round lane wrong");

    a_ob_no_flag: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        s_issue_op(UVSUB_OP_OB_HALF) or s_issue_op(UVSUB_OP_OB_HALF_RND) |=> !ctrl_write_o)
        else $error("halving form touched control word");

    a_uf_flag_set: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        s_issue_op(UVSUB_OP_QB_WRAP) ##0 (left_operand_reg_i[7:0] < right_operand_reg_i[7:0])
        |=> ctrl_write_o && ctrl_word_o[`UVSUB_UNDERFLOW_BIT])
        else $error("underflow flag not set");

    a_ctrl_keep: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        go |=> ctrl_word_o[19:0] == $past(ctrl_word_i[19:0]) && ctrl_word_o[31:21]
            == $past(ctrl_word_i[31:21]))
        else $error("other control bits changed");

    a_exc_only: assert property (@(posedge core_clk_i) disable iff (!rst_b_i)
        result_valid_o |-> !exc_reserved_o && !exc_disabled_o)
        else $error("exception with a result");
endmodule
